// >>> logic/sac_cfg.svh
// Constants for the slot address calculator
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH
// ----------------------------------------------------------------
// Address formula figures
// ----------------------------------------------------------------
`define SAC_DIG_RACK_MUL 12'h020
`define SAC_DIG_SLOT_MUL 12'h004
`define SAC_ANA_RACK_MUL 12'h080
`define SAC_ANA_SLOT_MUL 12'h010
`define SAC_ANA_BASE 12'h100
`define SAC_LINK_BASE 12'h7D0
`define SAC_LINK_RACK_MUL 12'h004
`define SAC_DSUB_BASE 12'h080
`define SAC_DSUB_MUL 12'h004
`define SAC_ASUB_BASE 12'h300
`define SAC_ASUB_MUL 12'h010
// ----------------------------------------------------------------
// Slot limits
// ----------------------------------------------------------------
`define SAC_SLOT_PSU 4'h1
`define SAC_SLOT_CPU 4'h2
`define SAC_SLOT_LINK 4'h3
`define SAC_SLOT_IO_LO 4'h4
`define SAC_SLOT_IO_HI 4'hB
`define SAC_SLOT_LINK0_HI 4'h6
`define SAC_SLOT_CEXP_HI 4'h5
`define SAC_SLOT_AEXP_LO 4'h5
`define SAC_RACK_MAX 2'h3
`define SAC_CARD_MAX 3'h5
`define SAC_ADDR_RESET 12'h000
`endif

// >>> logic/sac_pkg.sv
// Types for the slot address calculator
package sac_pkg;
  typedef enum logic [3:0] {
    SAC_CLS_DIGITAL,
    SAC_CLS_ANALOG,
    SAC_CLS_ANALOG_IO,
    SAC_CLS_FUNCTION,
    SAC_CLS_RACK_LINK,
    SAC_CLS_CPU_EXP,
    SAC_CLS_APP_EXP,
    SAC_CLS_BULK_STORE,
    SAC_CLS_SUB_DIGITAL,
    SAC_CLS_SUB_ANALOG,
    SAC_CLS_SUB_COUNTER,
    SAC_CLS_POWER,
    SAC_CLS_CPU
  } sac_class_t;
endpackage

// >>> logic/sac_slot_address_calculator.sv
// Slot-oriented module start address calculator
`include "sac_cfg.svh"

module sac_slot_address_calculator
  import sac_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic reset, // Async reset, active high
  input wire logic req_valid, // Request strobe
  input wire logic [1:0] rack_num, // Rack number
  input wire logic [2:0] rack_num_hi, // Upper rack bits, must be zero
  input wire logic [3:0] slot_num, // Slot number on the rack
  input wire logic [2:0] card_num, // Submodule card slot, from 1
  input wire sac_class_t mod_class, // Module class
  input wire logic [3:0] cpu_exp_count, // CPU expansions on rack 0
  input wire logic local_req, // Request from the carrying module
  input wire logic user_addr_en, // Use the user-chosen address
  input wire logic [ADDR_W-1:0] user_addr, // User-chosen address
  output logic [ADDR_W-1:0] start_addr, // Registered start address
  output logic addr_valid, // Address produced
  output logic no_addr, // Class has no start address
  output logic invalid // Placement or rack rejected
);
  // ----------------------------------------------------------------
  // Combinational placement check and formulas
  // ----------------------------------------------------------------
  // Result state and its next values
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic valid_r;
  logic valid_nxt;
  logic none_r;
  logic none_nxt;
  logic inv_r;
  logic inv_nxt;
  // Widened request fields and derived slot positions
  logic [ADDR_W-1:0] rack_w;
  logic [ADDR_W-1:0] slot_off;
  logic [ADDR_W-1:0] card_off;
  logic [4:0] link0_slot;
  logic [4:0] slot_ext;
  // Class groups and placement verdicts
  logic cls_io;
  logic cls_sub;
  logic cls_user;
  logic io_slot;
  logic card_ok;
  logic rack_ok;
  logic ok;

  // Widen fields once so products cannot overflow
  always_comb begin
    rack_w = ADDR_W'(rack_num);
    // Slots below 4 wrap here, but those requests are refused before use
    slot_off = ADDR_W'(slot_num) - ADDR_W'(`SAC_SLOT_IO_LO);
    card_off = ADDR_W'(card_num) - ADDR_W'(1);
    // One spare bit so a large expansion count cannot wrap onto a low slot
    slot_ext = {1'b0, slot_num};
    link0_slot = 5'(`SAC_SLOT_LINK) + {1'b0, cpu_exp_count};
    io_slot = (slot_num >= `SAC_SLOT_IO_LO) && (slot_num <= `SAC_SLOT_IO_HI);
    card_ok = (card_num >= 3'h1) && (card_num <= `SAC_CARD_MAX);
    rack_ok = (rack_num_hi == 3'h0);
  end

  // ----------------------------------------------------------------
  // Class groups
  // ----------------------------------------------------------------
  // Grouped once so the placement and override tests stay short
  always_comb begin
    cls_io = 1'b0;
    cls_sub = 1'b0;
    unique case (mod_class)
      SAC_CLS_DIGITAL, SAC_CLS_ANALOG, SAC_CLS_ANALOG_IO, SAC_CLS_FUNCTION: begin
        cls_io = 1'b1;
      end
      SAC_CLS_SUB_DIGITAL, SAC_CLS_SUB_ANALOG, SAC_CLS_SUB_COUNTER: begin
        cls_sub = 1'b1;
      end
      default: begin
        cls_io = 1'b0;
      end
    endcase
    // Only signal and function modules take a software-chosen address
    cls_user = cls_io;
  end

  // ----------------------------------------------------------------
  // Next result
  // ----------------------------------------------------------------
  // Next result; invalid requests clear the address rather than hold it
  always_comb begin
    addr_nxt = addr_r;
    valid_nxt = valid_r;
    none_nxt = none_r;
    inv_nxt = inv_r;
    ok = 1'b0;
    if (req_valid) begin
      addr_nxt = `SAC_ADDR_RESET;
      valid_nxt = 1'b0;
      none_nxt = 1'b0;
      unique case (mod_class)
        SAC_CLS_DIGITAL, SAC_CLS_ANALOG, SAC_CLS_ANALOG_IO, SAC_CLS_FUNCTION: begin
          // The reserved link slot on rack 0 may not hold I/O
          ok = io_slot && !(rack_num == 2'h0 && slot_ext == link0_slot);
        end
        SAC_CLS_RACK_LINK: begin
          // Rack 0 link slot floats with the expansion count; other racks fix it
          if (rack_num == 2'h0)
            ok = (slot_ext == link0_slot) && (slot_num <= `SAC_SLOT_LINK0_HI);
          else
            ok = (slot_num == `SAC_SLOT_LINK);
        end
        SAC_CLS_CPU_EXP, SAC_CLS_BULK_STORE: begin
          // CPU expansions only sit to the right of the CPU on rack 0
          ok = (rack_num == 2'h0) && (slot_num >= `SAC_SLOT_LINK) &&
               (slot_num <= `SAC_SLOT_CEXP_HI);
        end
        SAC_CLS_APP_EXP: begin
          // An application module may carry expansions on any rack
          ok = (slot_num >= `SAC_SLOT_AEXP_LO) && (slot_num <= `SAC_SLOT_IO_HI);
        end
        SAC_CLS_SUB_DIGITAL, SAC_CLS_SUB_ANALOG, SAC_CLS_SUB_COUNTER: begin
          // Card slots count from 1; rack and slot play no part
          ok = card_ok;
        end
        SAC_CLS_POWER: begin
          // The supply holds the first slot on every rack
          ok = (slot_num == `SAC_SLOT_PSU);
        end
        SAC_CLS_CPU: begin
          // Only rack 0 carries the CPU
          ok = (rack_num == 2'h0) && (slot_num == `SAC_SLOT_CPU);
        end
        default: begin
          ok = 1'b0;
        end
      endcase
      // Only the carrying module may reach its submodules
      if (cls_sub && !local_req)
        ok = 1'b0;
      if (!rack_ok)
        ok = 1'b0;
      // A refused request leaves a zero address and only the invalid flag
      inv_nxt = !ok;
      if (ok) begin
        unique case (mod_class)
          SAC_CLS_DIGITAL, SAC_CLS_FUNCTION: begin
            addr_nxt = ADDR_W'(rack_w * `SAC_DIG_RACK_MUL + slot_off * `SAC_DIG_SLOT_MUL);
            valid_nxt = 1'b1;
          end
          SAC_CLS_ANALOG, SAC_CLS_ANALOG_IO: begin
            // One address serves both directions of a combined module
            addr_nxt = ADDR_W'(rack_w * `SAC_ANA_RACK_MUL + slot_off * `SAC_ANA_SLOT_MUL
                       + `SAC_ANA_BASE);
            valid_nxt = 1'b1;
          end
          SAC_CLS_RACK_LINK: begin
            // The slot plays no part in the link module address
            addr_nxt = ADDR_W'(`SAC_LINK_BASE + rack_w * `SAC_LINK_RACK_MUL);
            valid_nxt = 1'b1;
          end
          SAC_CLS_SUB_DIGITAL: begin
            addr_nxt = ADDR_W'(`SAC_DSUB_BASE + card_off * `SAC_DSUB_MUL);
            valid_nxt = 1'b1;
          end
          SAC_CLS_SUB_ANALOG, SAC_CLS_SUB_COUNTER: begin
            addr_nxt = ADDR_W'(`SAC_ASUB_BASE + card_off * `SAC_ASUB_MUL);
            valid_nxt = 1'b1;
          end
          default: begin
            // Expansions, storage, supply and CPU hold no address of their own
            none_nxt = 1'b1;
          end
        endcase
        // Software-chosen address only overrides signal and function modules
        if (user_addr_en && cls_user) begin
          addr_nxt = user_addr;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  // Asynchronous clear; the first request after release is taken normally
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addr_r <= `SAC_ADDR_RESET;
      valid_r <= 1'b0;
      none_r <= 1'b0;
      inv_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      valid_r <= valid_nxt;
      none_r <= none_nxt;
      inv_r <= inv_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output comes straight from a flip-flop, so nothing glitches downstream
  assign start_addr = addr_r;
  assign addr_valid = valid_r;
  assign no_addr = none_r;
  assign invalid = inv_r;
endmodule

// >>> tb/sac_chk_sva.sv
// Assertion checker for the slot address calculator
module sac_chk_sva
  import sac_pkg::*;
#(parameter int ADDR_W = 12) (
  input wire logic mclk, // Clock
  input wire logic reset, // Reset
  input wire logic req_valid, // Strobe
  input wire logic [1:0] rack_num, // Rack
  input wire logic [2:0] rack_num_hi, // Upper rack
  input wire logic [3:0] slot_num, // Slot
  input wire logic [2:0] card_num, // Card
  input wire sac_class_t mod_class, // Class
  input wire logic [3:0] cpu_exp_count, // Expansions
  input wire logic local_req, // Local
  input wire logic user_addr_en, // User select
  input wire logic [ADDR_W-1:0] start_addr, // Address
  input wire logic addr_valid, // Produced
  input wire logic no_addr, // None
  input wire logic invalid // Rejected
);
  // Expected figures, wrapped to the address width as the hardware does
  logic [ADDR_W-1:0] dig_e, ana_e, lnk_e, sdg_e, san_e;
  wire io_ok = slot_num >= 4'h4 && slot_num <= 4'hB
    && !(rack_num == 2'h0 && slot_num == cpu_exp_count + 4'h3);
  wire sub_ok = local_req && card_num >= 3'h1 && card_num <= 3'h5;
  assign dig_e = 12'h020 * rack_num + 12'h004 * slot_num - 12'h010;
  assign ana_e = 12'h080 * rack_num + 12'h010 * slot_num - 12'h040 + 12'h100;
  assign lnk_e = 12'h7D0 + 12'h004 * rack_num;
  assign sdg_e = 12'h080 + 12'h004 * card_num - 12'h004;
  assign san_e = 12'h300 + 12'h010 * card_num - 12'h010;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // A request taken for one class on a rack within range
  sequence ask_s(sac_class_t c);
    req_valid && mod_class == c && !user_addr_en && rack_num_hi == 3'h0;
  endsequence
  dig_addr_a: assert property (ask_s(SAC_CLS_DIGITAL) ##0 io_ok |=>
    addr_valid && start_addr == $past(dig_e)) else $error("digital address wrong");
  ana_addr_a: assert property (ask_s(SAC_CLS_ANALOG) ##0 io_ok |=>
    addr_valid && start_addr == $past(ana_e)) else $error("analog address wrong");
  link_addr_a: assert property (ask_s(SAC_CLS_RACK_LINK) ##0
    (rack_num != 2'h0 && slot_num == 4'h3) |=> addr_valid && start_addr == $past(lnk_e))
    else $error("link address wrong");
  sub_dig_a: assert property (ask_s(SAC_CLS_SUB_DIGITAL) ##0 sub_ok |=>
    addr_valid && start_addr == $past(sdg_e)) else $error("digital card address wrong");
  sub_ana_a: assert property (ask_s(SAC_CLS_SUB_ANALOG) ##0 sub_ok |=>
    addr_valid && start_addr == $past(san_e)) else $error("analog card address wrong");
  no_addr_a: assert property (req_valid && (mod_class == SAC_CLS_CPU_EXP
    || mod_class == SAC_CLS_BULK_STORE) |=> !addr_valid && start_addr == 12'h000)
    else $error("expansion got an address");
  rack_bad_a: assert property (req_valid && rack_num_hi != 3'h0 |=>
    invalid && !addr_valid) else $error("high rack not rejected");
  rst_clear_a: assert property ($past(reset) |->
    start_addr == 12'h000 && !addr_valid) else $error("outputs not cleared by reset");
  power_none_a: assert property (ask_s(SAC_CLS_POWER) ##0 slot_num == 4'h1 |=>
    no_addr && !addr_valid && !invalid && start_addr == 12'h000)
    else $error("supply placement not accepted without address");
endmodule

bind sac_slot_address_calculator sac_chk_sva #(.ADDR_W(ADDR_W)) i_chk (.mclk, .reset,
  .req_valid, .rack_num, .rack_num_hi, .slot_num, .card_num, .mod_class, .cpu_exp_count,
  .local_req, .user_addr_en, .start_addr, .addr_valid, .no_addr, .invalid);

// >>> tb/sac_cpu_model.sv
// Model of the CPU I/O access logic that asks for start addresses
module sac_cpu_model
  import sac_pkg::*;
(
  input wire logic mclk, // Clock
  output logic req_valid, // Strobe
  output logic [1:0] rack_num, // Rack
  output logic [2:0] rack_num_hi, // Upper rack
  output logic [3:0] slot_num, // Slot
  output logic [2:0] card_num, // Card
  output sac_class_t mod_class, // Class
  output logic [3:0] cpu_exp_count, // Expansions
  output logic local_req, // Local
  output logic user_addr_en, // User select
  output logic [11:0] user_addr // User address
);
  // Idle at time zero so nothing is asked during reset
  initial begin
    {req_valid, rack_num, rack_num_hi, slot_num, card_num, cpu_exp_count} = '0;
    {local_req, user_addr_en, user_addr} = '0;
    mod_class = SAC_CLS_DIGITAL;
  end
  // One request; rack and slot fields scrambled after so held outputs cannot lean on them
  task automatic ask(input sac_class_t c, input logic [4:0] rk, input logic [3:0] sl,
    input logic [2:0] cd = 3'h0, input logic [3:0] ex = 4'h0, input logic lc = 1'b0,
    input logic [12:0] ua = 13'h0000);
    @(posedge mclk);
    req_valid <= 1'b1;
    mod_class <= c;
    {rack_num_hi, rack_num, slot_num} <= {rk, sl};
    {card_num, cpu_exp_count, local_req} <= {cd, ex, lc};
    {user_addr_en, user_addr} <= ua;
    @(posedge mclk);
    req_valid <= 1'b0;
    {rack_num_hi, rack_num, slot_num} <= ~{rk, sl};
  endtask
endmodule

// >>> tb/sac_slot_address_calculator_tb.sv
// Self-checking bench for the slot address calculator
module sac_slot_address_calculator_tb
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset, req_valid, local_req, user_addr_en, addr_valid, no_addr, invalid;
  logic [1:0] rack_num;
  logic [2:0] rack_num_hi, card_num;
  logic [3:0] slot_num, cpu_exp_count;
  logic [11:0] user_addr, start_addr;
  sac_class_t mod_class;
  int n_mismatch, cmp_count;
  sac_cpu_model i_cpu (.mclk, .req_valid, .rack_num, .rack_num_hi, .slot_num, .card_num,
    .mod_class, .cpu_exp_count, .local_req, .user_addr_en, .user_addr);
  sac_slot_address_calculator i_dut (.mclk, .reset, .req_valid, .rack_num, .rack_num_hi,
    .slot_num, .card_num, .mod_class, .cpu_exp_count, .local_req, .user_addr_en,
    .user_addr, .start_addr, .addr_valid, .no_addr, .invalid);
  // Flags are {addr_valid, no_addr, invalid}; checked 1 ns after the answer edge
  task automatic chk(input logic [11:0] ea, input logic [2:0] ef);
    #1;
    cmp_count++;
    if ({start_addr, addr_valid, no_addr, invalid} !== {ea, ef}) begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time,
        {start_addr, addr_valid, no_addr, invalid}, {ea, ef});
    end
  endtask
  task automatic t_signal();
    i_cpu.ask(SAC_CLS_DIGITAL, 5'h01, 4'h5);
    chk(12'h024, 3'h4);
    i_cpu.ask(SAC_CLS_ANALOG, 5'h00, 4'h6, 3'h0, 4'h2);
    chk(12'h120, 3'h4);
    i_cpu.ask(SAC_CLS_ANALOG_IO, 5'h03, 4'hB);
    chk(12'h2F0, 3'h4);
    i_cpu.ask(SAC_CLS_FUNCTION, 5'h01, 4'h3);
    chk(12'h000, 3'h1);
  endtask
  task automatic t_link_sub();
    i_cpu.ask(SAC_CLS_RACK_LINK, 5'h00, 4'h5, 3'h0, 4'h2);
    chk(12'h7D0, 3'h4);
    i_cpu.ask(SAC_CLS_RACK_LINK, 5'h02, 4'h4);
    chk(12'h000, 3'h1);
    i_cpu.ask(SAC_CLS_SUB_COUNTER, 5'h00, 4'h3, 3'h5, 4'h0, 1'b1);
    chk(12'h340, 3'h4);
    i_cpu.ask(SAC_CLS_SUB_DIGITAL, 5'h00, 4'h3, 3'h1, 4'h0, 1'b0);
    chk(12'h000, 3'h1);
  endtask
  task automatic t_none_bad();
    i_cpu.ask(SAC_CLS_BULK_STORE, 5'h00, 4'h5);
    chk(12'h000, 3'h2);
    i_cpu.ask(SAC_CLS_APP_EXP, 5'h01, 4'h4);
    chk(12'h000, 3'h1);
    i_cpu.ask(SAC_CLS_DIGITAL, 5'h04, 4'h4);
    chk(12'h000, 3'h1);
    i_cpu.ask(SAC_CLS_DIGITAL, 5'h01, 4'h5, 3'h0, 4'h0, 1'b0, 13'h1123);
    chk(12'h123, 3'h4);
    @(posedge mclk);
    chk(12'h123, 3'h4);
  endtask
  task automatic t_fixed();
    i_cpu.ask(SAC_CLS_POWER, 5'h02, 4'h1);
    chk(12'h000, 3'h2);
    i_cpu.ask(SAC_CLS_CPU, 5'h00, 4'h2);
    chk(12'h000, 3'h2);
    i_cpu.ask(SAC_CLS_CPU, 5'h01, 4'h2);
    chk(12'h000, 3'h1);
    i_cpu.ask(SAC_CLS_CPU_EXP, 5'h00, 4'h3);
    chk(12'h000, 3'h2);
    i_cpu.ask(SAC_CLS_SUB_DIGITAL, 5'h00, 4'h3, 3'h1, 4'h0, 1'b1);
    chk(12'h080, 3'h4);
    i_cpu.ask(SAC_CLS_SUB_ANALOG, 5'h02, 4'h7, 3'h2, 4'h0, 1'b1);
    chk(12'h310, 3'h4);
    i_cpu.ask(SAC_CLS_SUB_ANALOG, 5'h00, 4'h3, 3'h6, 4'h0, 1'b1);
    chk(12'h000, 3'h1);
    i_cpu.ask(SAC_CLS_DIGITAL, 5'h00, 4'h4, 3'h0, 4'h1);
    chk(12'h000, 3'h1);
    i_cpu.ask(SAC_CLS_RACK_LINK, 5'h00, 4'h7, 3'h0, 4'h4);
    chk(12'h000, 3'h1);
    i_cpu.ask(SAC_CLS_RACK_LINK, 5'h00, 4'h0, 3'h0, 4'hD);
    chk(12'h000, 3'h1);
    i_cpu.ask(SAC_CLS_RACK_LINK, 5'h01, 4'h3, 3'h0, 4'h0, 1'b0, 13'h1555);
    chk(12'h7D4, 3'h4);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Hang guard: far beyond the short run
  initial begin
    #20000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    reset = 1'b1;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    t_signal();
    t_link_sub();
    t_none_bad();
    t_fixed();
    reset <= 1'b1;
    chk(12'h000, 3'h0);
    finish_test();
  end
endmodule
